// ==== cap_electrode_touch_config_tb.sv ====
// Self-checking bench for the electrode touch configuration block
`timescale 1ns/1ps
module cap_electrode_touch_config_tb;
  localparam int MSC = 4;
  logic                  core_clk;
  logic                  nrst;
  cet_pkg::cet_reg_req_t req;
  logic [7:0]            rd_data_q;
  logic                  shutdown;
  logic                  sample_valid;
  logic [63:0]           sample_data;
  logic [3:0]            scan_enable_q;
  logic                  lp_scan_req_q;
  logic [3:0]            touch_status_q;
  logic                  wake_q;
  logic                  sample_go;
  logic [15:0]           lv [4];
  logic [63:0]           level;
  int                    err_total;
  int                    check_count;
  logic [7:0] rstv  [13] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h0A, 8'h0A, 8'h0A, 8'h0A,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] maskv [13] = '{8'h34, 8'hFF, 8'h3F, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'h7F,
                             8'h0F, 8'h0F, 8'h03, 8'h00, 8'h00};
  int         per   [16] = '{1, 5, 10, 15, 20, 30, 40, 50, 75, 100, 125, 150, 200, 300,
                             400, 500};

  // Clock at 100 MHz
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  assign level = {lv[3], lv[2], lv[1], lv[0]};

  cet_top #(.MS_CYCLES(MSC)) cet_top_inst (
    .core_clk       (core_clk),
    .nrst           (nrst),
    .reg_req        (req),
    .rd_data_q      (rd_data_q),
    .shutdown       (shutdown),
    .sample_valid   (sample_valid),
    .sample_data    (sample_data),
    .scan_enable_q  (scan_enable_q),
    .lp_scan_req_q  (lp_scan_req_q),
    .touch_status_q (touch_status_q),
    .wake_q         (wake_q)
  );

  cet_elec_model cet_elec_model_inst (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .scan_enable_q (scan_enable_q),
    .lp_scan_req_q (lp_scan_req_q),
    .sample_go     (sample_go),
    .level         (level),
    .sample_valid  (sample_valid),
    .sample_data   (sample_data)
  );

  // Inputs always move 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Strobe held one edge, then an idle edge so back-to-back calls never collide
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    tick(1);
    req = '0;
    tick(1);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    tick(1);
    req = '0;
    tick(1);
    chk(16'(rd_data_q), 16'(e), "register read");
  endtask

  // One sample each; four edges let the decision reach the status output
  task automatic smp(input int n);
    repeat (n) begin
      sample_go = 1'b1;
      tick(1);
      sample_go = 1'b0;
      tick(4);
    end
  endtask

  // Waits for a low-power scan pulse, then counts cycles to the next one
  task automatic gap(output int n);
    int k;
    k = 0;
    while (lp_scan_req_q !== 1'b1 && k < 2100) begin
      tick(1);
      k++;
    end
    n = 1;
    tick(1);
    while (lp_scan_req_q !== 1'b1 && n < 2100) begin
      tick(1);
      n++;
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run is near 25k cycles; a hang is cut at about 100k
  initial begin
    #1000000;
    err_total++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    int g;
    int w;
    nrst = 1'b0;
    req = '0;
    shutdown = 1'b0;
    sample_go = 1'b0;
    err_total = 0;
    check_count = 0;
    lv = '{16'h0064, 16'h0064, 16'h01F4, 16'h0064};
    tick(8);
    nrst = 1'b1;
    tick(1);
    for (g = 0; g < 13; g++) rdc(g[3:0], rstv[g]);
    for (g = 0; g < 13; g++) wr(g[3:0], 8'hFF);
    for (g = 0; g < 13; g++) rdc(g[3:0], maskv[g]);
    // Low-power flag is set now; a mid-run reset must drop it
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    rdc(4'h0, 8'h00);
    done("registers");
    wr(4'h8, 8'h05);
    tick(1);
    chk(16'(scan_enable_q), 16'h0005, "scan enables");
    wr(4'h0, 8'h04);
    tick(1);
    chk(16'(scan_enable_q), 16'h0000, "run scan with low-power flag");
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h03);
    wr(4'h8, 8'h03);
    tick(2);
    smp(1);
    lv[0] = 16'h006D;
    smp(3);
    chk(16'(touch_status_q), 16'h0000, "below threshold");
    lv[0] = 16'h006E;
    smp(2);
    chk(16'(touch_status_q), 16'h0000, "touch before count");
    smp(1);
    chk(16'(touch_status_q), 16'h0001, "touch confirmed");
    lv[0] = 16'h0064;
    smp(2);
    chk(16'(touch_status_q), 16'h0001, "release before count");
    smp(1);
    chk(16'(touch_status_q), 16'h0000, "release confirmed");
    done("touch");
    wr(4'h3, 8'h04);
    wr(4'h0, 8'h10);
    lv[0] = 16'h006E;
    smp(5);
    chk(16'(touch_status_q), 16'h0001, "before stuck timeout");
    smp(3);
    chk(16'(touch_status_q), 16'h0000, "stuck recalibrated");
    smp(3);
    chk(16'(touch_status_q), 16'h0000, "new baseline holds");
    wr(4'h3, 8'h00);
    lv[0] = 16'h0078;
    smp(11);
    chk(16'(touch_status_q), 16'h0001, "timeout zero keeps touch");
    done("stuck");
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h20);
    lv[1] = 16'h0069;
    smp(20);
    lv[1] = 16'h006E;
    smp(1);
    chk(16'(touch_status_q[1]), 16'h0001, "rate zero holds baseline");
    lv[1] = 16'h0069;
    wr(4'h1, 8'h02);
    // Release, then steps every second sample; an odd count leaves the next sample stepless
    smp(23);
    lv[1] = 16'h0072;
    smp(1);
    chk(16'(touch_status_q[1]), 16'h0000, "baseline followed");
    lv[1] = 16'h0073;
    smp(1);
    chk(16'(touch_status_q[1]), 16'h0001, "touch over new baseline");
    done("drift");
    lv[2] = 16'h0064;
    // The wake electrode must be enabled, or its slice stays idle
    wr(4'h8, 8'h07);
    wr(4'hA, 8'h02);
    wr(4'h0, 8'h04);
    shutdown = 1'b1;
    tick(2);
    chk(16'(scan_enable_q), 16'h0004, "shutdown electrode");
    for (g = 0; g < 16; g++) begin
      wr(4'h9, g[7:0]);
      gap(w);
      gap(w);
      chk(w[15:0], 16'(per[g] * MSC), "low-power period");
    end
    wr(4'h9, 8'h00);
    gap(w);
    lv[2] = 16'h006E;
    w = 0;
    for (g = 0; g < 60; g++) begin
      tick(1);
      if (wake_q === 1'b1) w++;
    end
    chk(w[15:0], 16'h0001, "single wake pulse");
    shutdown = 1'b0;
    done("low power");
    give_verdict();
  end
endmodule

// ==== cet_elec_model.sv ====
// Partner model: four capacitive electrodes answering scan requests with readings
`timescale 1ns/1ps
module cet_elec_model (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  scan_enable_q,
  input  wire logic        lp_scan_req_q,
  input  wire logic        sample_go,
  input  wire logic [63:0] level,
  output logic             sample_valid,
  output logic [63:0]      sample_data
);
  // Outside a scan, or for an unscanned electrode, the lane carries the inverted level
  // so that a design using stale or unscanned data sees a large false reading
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sample_valid <= 1'b0;
      sample_data  <= 64'h0;
    end else begin
      sample_valid <= sample_go | lp_scan_req_q;
      for (int g = 0; g < 4; g++) begin
        sample_data[g*16 +: 16] <= (scan_enable_q[g] & (sample_go | lp_scan_req_q)) ?
                                   level[g*16 +: 16] : ~level[g*16 +: 16];
      end
    end
  end
endmodule

// ==== cet_electrode.sv ====
// One electrode slice: baseline, touch decision, confirmation, drift and stuck handling
`timescale 1ns/1ps
module cet_electrode (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   sample_valid,
  input  wire logic [15:0]            reading,
  input  wire cet_pkg::cet_elec_cfg_t cfg,
  output logic                        touched_q,
  output logic [15:0]                 baseline_q
);
  logic        init_q;
  logic [5:0]  conf_cnt_q;
  logic [7:0]  track_cnt_q;
  logic [7:0]  stuck_cnt_q;
  logic [6:0]  thr;
  logic [5:0]  need;
  logic [16:0] level;
  logic        raw_touch;
  logic        confirm_hit;
  logic        stuck_fire;
  logic        track_fire;

  // Clamp out-of-range settings so a bad write never stalls the decision
  always_comb begin
    thr = (cfg.threshold < cet_pkg::THR_MIN) ? cet_pkg::THR_MIN : cfg.threshold;
    need = cfg.confirm;
    if (cfg.confirm < cet_pkg::CONFIRM_MIN) begin
      need = cet_pkg::CONFIRM_MIN;
    end else if (cfg.confirm > cet_pkg::CONFIRM_MAX) begin
      need = cet_pkg::CONFIRM_MAX;
    end
    level = {1'b0, baseline_q} + {10'h000, thr};
    raw_touch = init_q && ({1'b0, reading} >= level);
    confirm_hit = (raw_touch != touched_q) && ((conf_cnt_q + 6'h01) >= need);
    stuck_fire = cfg.stuck_on && (cfg.stuck_tout != 8'h00) && touched_q
                 && ((stuck_cnt_q + 8'h01) >= cfg.stuck_tout);
    track_fire = cfg.track_on && (cfg.track_rate != 8'h00) && !touched_q
                 && ((track_cnt_q + 8'h01) >= cfg.track_rate);
  end

  // Baseline: first sample seeds it, stuck recal reloads it, drift steps it by one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      init_q     <= 1'b0;
      baseline_q <= 16'h0000;
    end else if (!cfg.enable) begin
      init_q <= 1'b0;
    end else if (sample_valid) begin
      if (!init_q) begin
        init_q     <= 1'b1;
        baseline_q <= reading;
      end else if (stuck_fire) begin
        baseline_q <= reading;
      end else if (track_fire) begin
        if (reading > baseline_q) begin
          baseline_q <= baseline_q + 16'h0001;
        end else if (reading < baseline_q) begin
          baseline_q <= baseline_q - 16'h0001;
        end
      end
    end
  end

  // Touch state changes only after enough disagreeing samples in a row, or clears on stuck recal or disable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      touched_q  <= 1'b0;
      conf_cnt_q <= 6'h00;
    end else if (!cfg.enable) begin
      touched_q  <= 1'b0;
      conf_cnt_q <= 6'h00;
    end else if (sample_valid && init_q) begin
      if (stuck_fire) begin
        touched_q  <= 1'b0;
        conf_cnt_q <= 6'h00;
      end else if (confirm_hit) begin
        touched_q  <= raw_touch;
        conf_cnt_q <= 6'h00;
      end else if (raw_touch != touched_q) begin
        conf_cnt_q <= conf_cnt_q + 6'h01;
      end else begin
        conf_cnt_q <= 6'h00;
      end
    end
  end

  // Stuck timer counts sample periods spent touched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stuck_cnt_q <= 8'h00;
    end else if (!cfg.enable) begin
      stuck_cnt_q <= 8'h00;
    end else if (sample_valid) begin
      if (touched_q && cfg.stuck_on && (cfg.stuck_tout != 8'h00) && !stuck_fire) begin
        stuck_cnt_q <= stuck_cnt_q + 8'h01;
      end else begin
        stuck_cnt_q <= 8'h00;
      end
    end
  end

  // Drift stride counter; cleared while touched so a finger is not absorbed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      track_cnt_q <= 8'h00;
    end else if (!cfg.enable) begin
      track_cnt_q <= 8'h00;
    end else if (sample_valid) begin
      if (cfg.track_on && (cfg.track_rate != 8'h00) && !touched_q && !track_fire) begin
        track_cnt_q <= track_cnt_q + 8'h01;
      end else begin
        track_cnt_q <= 8'h00;
      end
    end
  end

  hold_confirm_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.enable && sample_valid && init_q && !stuck_fire && !confirm_hit
    |=> touched_q == $past(touched_q))
    else $error("touch state changed before confirm count");

  touch_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(touched_q) |-> $past(raw_touch) && $past(sample_valid))
    else $error("touch set without reading over threshold");

  stuck_recal_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.enable && sample_valid && init_q && stuck_fire
    |=> !touched_q && baseline_q == $past(reading))
    else $error("stuck electrode not recalibrated");

  rate_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.enable && init_q && cfg.track_rate == 8'h00 && !stuck_fire
    |=> $stable(baseline_q))
    else $error("baseline moved with drift rate zero");

  disabled_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !cfg.enable |=> !touched_q && stuck_cnt_q == 8'h00 && track_cnt_q == 8'h00)
    else $error("disabled electrode not idle");
endmodule

// ==== cet_pkg.sv ====
// Shared constants, register map and carrier types for the electrode touch block
package cet_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  // Sizes
  localparam int NUM_ELEC = 4;
  localparam int SAMPLE_W = 16;
  // Register offsets on the configuration port
  localparam logic [3:0] ADDR_CFG     = 4'h0;
  localparam logic [3:0] ADDR_RATE    = 4'h1;
  localparam logic [3:0] ADDR_CONFIRM = 4'h2;
  localparam logic [3:0] ADDR_TOUT    = 4'h3;
  localparam logic [3:0] ADDR_THR0    = 4'h4;
  localparam logic [3:0] ADDR_THR3    = 4'h7;
  localparam logic [3:0] ADDR_EN      = 4'h8;
  localparam logic [3:0] ADDR_LOW_POWER_SCAN_CODE    = 4'h9;
  localparam logic [3:0] ADDR_LOW_POWER_ELECTRODE_SELECT    = 4'hA;
  localparam logic [3:0] ADDR_STATUS  = 4'hB;
  // Field positions in the system configuration register
  localparam int CFG_DRIFT_BIT = 5;
  localparam int CFG_STUCK_BIT = 4;
  localparam int CFG_LP_BIT    = 2;
  // Writable bit masks
  localparam logic [7:0] CFG_MASK     = 8'h34;
  localparam logic [7:0] CONFIRM_MASK = 8'h3F;
  localparam logic [7:0] THR_MASK     = 8'h7F;
  localparam logic [7:0] EN_MASK      = 8'h0F;
  localparam logic [7:0] LOW_POWER_SCAN_CODE_MASK    = 8'h0F;
  localparam logic [7:0] LOW_POWER_ELECTRODE_SELECT_MASK    = 8'h03;
  // Reset values
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] RST_RATE    = 8'h00;
  localparam logic [7:0] RST_CONFIRM = 8'h01;
  localparam logic [7:0] RST_TOUT    = 8'h00;
  localparam logic [7:0] RST_THR     = 8'h0A;
  localparam logic [7:0] RST_EN      = 8'h00;
  localparam logic [7:0] RST_LOW_POWER_SCAN_CODE    = 8'h00;
  localparam logic [7:0] RST_LOW_POWER_ELECTRODE_SELECT    = 8'h00;
  // Legal ranges
  localparam logic [5:0] CONFIRM_MIN = 6'h01;
  localparam logic [5:0] CONFIRM_MAX = 6'h20;
  localparam logic [6:0] THR_MIN     = 7'h02;

  // Per-electrode configuration carried into each electrode slice
  typedef struct packed {
    logic       enable;
    logic [6:0] threshold;
    logic [5:0] confirm;
    logic       track_on;
    logic [7:0] track_rate;
    logic       stuck_on;
    logic [7:0] stuck_tout;
  } cet_elec_cfg_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } cet_reg_req_t;

  // Low-power scan period code to interval in ms (not linear)
  function automatic logic [8:0] cet_lp_period_ms(input logic [3:0] code);
    logic [8:0] ms;
    ms = 9'h001;
    case (code)
      4'h0: ms = 9'h001;
      4'h1: ms = 9'h005;
      4'h2: ms = 9'h00A;
      4'h3: ms = 9'h00F;
      4'h4: ms = 9'h014;
      4'h5: ms = 9'h01E;
      4'h6: ms = 9'h028;
      4'h7: ms = 9'h032;
      4'h8: ms = 9'h04B;
      4'h9: ms = 9'h064;
      4'hA: ms = 9'h07D;
      4'hB: ms = 9'h096;
      4'hC: ms = 9'h0C8;
      4'hD: ms = 9'h12C;
      4'hE: ms = 9'h190;
      4'hF: ms = 9'h1F4;
      default: ms = 9'h001;
    endcase
    return ms;
  endfunction
endpackage

// ==== cet_top.sv ====
// Capacitive electrode configuration registers, scan control and touch decisions
`timescale 1ns/1ps
// Functional notes
// - Drift enable keeps adjusting each untouched baseline
// - One baseline step per rate samples
// - Drift rate zero disables tracking
// - Stuck electrode recalibrates baseline, reads released
// - Stuck timeout zero disables recalibration
// - Stuck timeout counts sensing periods
// - Status change needs n confirming samples
// - Touch when reading reaches baseline+threshold
// - Enable bits 3..0 gate electrode scanning; in shutdown low-power mode the selected electrode is scanned whatever its bit
// - Low-power flag lets one electrode wake
// - Low-power flag stops all run-mode scanning
// - Low-power flag always zero after reset
// - Scan period value is a code
// - Codes 0000..1111 select 1..500 ms
// - Two-bit select picks shutdown electrode
module cet_top #(
  parameter int MS_CYCLES = cet_pkg::MS_CYCLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire cet_pkg::cet_reg_req_t reg_req,
  output logic [7:0]                 rd_data_q,
  input  wire logic                  shutdown,
  input  wire logic                  sample_valid,
  input  wire logic [63:0]           sample_data,
  output logic [3:0]                 scan_enable_q,
  output logic                       lp_scan_req_q,
  output logic [3:0]                 touch_status_q,
  output logic                       wake_q
);
  typedef enum logic [2:0] {
    CET_RUN    = 3'b001,
    CET_LP_ARM = 3'b010,
    CET_SD_LP  = 3'b100
  } cet_mode_t;

  logic [7:0]  cfg_q;
  logic [7:0]  rate_q;
  logic [7:0]  confirm_q;
  logic [7:0]  tout_q;
  logic [7:0]  thr_q [4];
  logic [7:0]  en_q;
  logic [7:0]  low_power_scan_code_q;
  logic [7:0]  low_power_electrode_select_q;
  logic [7:0]  rd_d;
  logic [3:0]  scan_d;
  logic [3:0]  elec_touched;
  logic [8:0]  lp_ms_q;
  logic [8:0]  lp_ms_lim;
  logic [31:0] tick_cnt_q;
  logic        lp_flag;
  cet_mode_t   mode_d;
  cet_mode_t   mode_q;
  logic [7:0]  rd_mask;
  logic [31:0] lp_period;
  logic [31:0] lp_gap_q;
  logic        lp_gap_ok_q;

  assign lp_flag = cfg_q[cet_pkg::CFG_LP_BIT];

  // Register writes; only documented field bits are stored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q     <= cet_pkg::RST_CFG;
      rate_q    <= cet_pkg::RST_RATE;
      confirm_q <= cet_pkg::RST_CONFIRM;
      tout_q    <= cet_pkg::RST_TOUT;
      en_q      <= cet_pkg::RST_EN;
      low_power_scan_code_q    <= cet_pkg::RST_LOW_POWER_SCAN_CODE;
      low_power_electrode_select_q    <= cet_pkg::RST_LOW_POWER_ELECTRODE_SELECT;
      for (int i = 0; i < cet_pkg::NUM_ELEC; i++) begin
        thr_q[i] <= cet_pkg::RST_THR;
      end
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        cet_pkg::ADDR_CFG:     cfg_q     <= reg_req.data & cet_pkg::CFG_MASK;
        cet_pkg::ADDR_RATE:    rate_q    <= reg_req.data;
        cet_pkg::ADDR_CONFIRM: confirm_q <= reg_req.data & cet_pkg::CONFIRM_MASK;
        cet_pkg::ADDR_TOUT:    tout_q    <= reg_req.data;
        cet_pkg::ADDR_EN:      en_q      <= reg_req.data & cet_pkg::EN_MASK;
        cet_pkg::ADDR_LOW_POWER_SCAN_CODE:    low_power_scan_code_q    <= reg_req.data & cet_pkg::LOW_POWER_SCAN_CODE_MASK;
        cet_pkg::ADDR_LOW_POWER_ELECTRODE_SELECT:    low_power_electrode_select_q    <= reg_req.data & cet_pkg::LOW_POWER_ELECTRODE_SELECT_MASK;
        default: begin
          if (reg_req.addr >= cet_pkg::ADDR_THR0 && reg_req.addr <= cet_pkg::ADDR_THR3) begin
            thr_q[reg_req.addr[1:0]] <= reg_req.data & cet_pkg::THR_MASK;
          end
        end
      endcase
    end
  end

  // Read mux; unmapped offsets return zero
  always_comb begin
    rd_d = 8'h00;
    case (reg_req.addr)
      cet_pkg::ADDR_CFG:     rd_d = cfg_q;
      cet_pkg::ADDR_RATE:    rd_d = rate_q;
      cet_pkg::ADDR_CONFIRM: rd_d = confirm_q;
      cet_pkg::ADDR_TOUT:    rd_d = tout_q;
      cet_pkg::ADDR_EN:      rd_d = en_q;
      cet_pkg::ADDR_LOW_POWER_SCAN_CODE:    rd_d = low_power_scan_code_q;
      cet_pkg::ADDR_LOW_POWER_ELECTRODE_SELECT:    rd_d = low_power_electrode_select_q;
      cet_pkg::ADDR_STATUS:  rd_d = {4'h0, touch_status_q};
      default: begin
        if (reg_req.addr >= cet_pkg::ADDR_THR0 && reg_req.addr <= cet_pkg::ADDR_THR3) begin
          rd_d = thr_q[reg_req.addr[1:0]];
        end
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 8'h00;
    end else if (reg_req.rd) begin
      rd_data_q <= rd_d;
    end
  end

  // Writable-bit mask of the addressed register; reserved bits must read back zero
  always_comb begin
    rd_mask = 8'h00;
    case (reg_req.addr)
      cet_pkg::ADDR_CFG:     rd_mask = cet_pkg::CFG_MASK;
      cet_pkg::ADDR_RATE:    rd_mask = 8'hFF;
      cet_pkg::ADDR_CONFIRM: rd_mask = cet_pkg::CONFIRM_MASK;
      cet_pkg::ADDR_TOUT:    rd_mask = 8'hFF;
      cet_pkg::ADDR_EN:      rd_mask = cet_pkg::EN_MASK;
      cet_pkg::ADDR_LOW_POWER_SCAN_CODE:    rd_mask = cet_pkg::LOW_POWER_SCAN_CODE_MASK;
      cet_pkg::ADDR_LOW_POWER_ELECTRODE_SELECT:    rd_mask = cet_pkg::LOW_POWER_ELECTRODE_SELECT_MASK;
      cet_pkg::ADDR_STATUS:  rd_mask = 8'h0F;
      default: begin
        if (reg_req.addr >= cet_pkg::ADDR_THR0 && reg_req.addr <= cet_pkg::ADDR_THR3) begin
          rd_mask = cet_pkg::THR_MASK;
        end
      end
    endcase
  end

  // Operating mode follows the shutdown input and the low-power flag
  always_comb begin
    if (shutdown && lp_flag) begin
      mode_d = CET_SD_LP;
    end else if (lp_flag) begin
      mode_d = CET_LP_ARM;
    end else begin
      mode_d = CET_RUN;
    end
  end

  // Which electrodes are scanned in each mode
  always_comb begin
    case (mode_d)
      CET_RUN:    scan_d = shutdown ? 4'h0 : en_q[3:0];
      CET_LP_ARM: scan_d = 4'h0;
      CET_SD_LP:  scan_d = 4'(4'h1 << low_power_electrode_select_q[1:0]);
      default:    scan_d = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q        <= CET_RUN;
      scan_enable_q <= 4'h0;
    end else begin
      mode_q        <= mode_d;
      scan_enable_q <= scan_d;
    end
  end

  // Low-power scan pacing: a ms prescaler and a ms counter against the coded limit
  assign lp_ms_lim = cet_pkg::cet_lp_period_ms(low_power_scan_code_q[3:0]);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q    <= 32'h0000_0000;
      lp_ms_q       <= 9'h000;
      lp_scan_req_q <= 1'b0;
    end else if (mode_q != CET_SD_LP) begin
      tick_cnt_q    <= 32'h0000_0000;
      lp_ms_q       <= 9'h000;
      lp_scan_req_q <= 1'b0;
    end else if (tick_cnt_q == 32'(MS_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      if (lp_ms_q + 9'h001 >= lp_ms_lim) begin
        lp_ms_q       <= 9'h000;
        lp_scan_req_q <= 1'b1;
      end else begin
        lp_ms_q       <= lp_ms_q + 9'h001;
        lp_scan_req_q <= 1'b0;
      end
    end else begin
      tick_cnt_q    <= tick_cnt_q + 32'h0000_0001;
      lp_scan_req_q <= 1'b0;
    end
  end

  // Independent pacing check; a code write or leaving shutdown voids the next gap
  assign lp_period = 32'(lp_ms_lim) * 32'(MS_CYCLES);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lp_gap_q    <= 32'h0000_0000;
      lp_gap_ok_q <= 1'b0;
    end else if (mode_q != CET_SD_LP
                 || (reg_req.wr && reg_req.addr == cet_pkg::ADDR_LOW_POWER_SCAN_CODE)) begin
      lp_gap_q    <= 32'h0000_0000;
      lp_gap_ok_q <= 1'b0;
    end else if (lp_scan_req_q) begin
      lp_gap_q    <= 32'h0000_0001;
      lp_gap_ok_q <= 1'b1;
    end else begin
      lp_gap_q <= lp_gap_q + 32'h0000_0001;
    end
  end

  // Electrode slices; samples only reach electrodes that are being scanned
  for (genvar g = 0; g < cet_pkg::NUM_ELEC; g++) begin : g_elec
    cet_pkg::cet_elec_cfg_t ecfg;
    always_comb begin
      ecfg.enable     = en_q[g];
      ecfg.threshold  = thr_q[g][6:0];
      ecfg.confirm    = confirm_q[5:0];
      ecfg.track_on   = cfg_q[cet_pkg::CFG_DRIFT_BIT];
      ecfg.track_rate = rate_q;
      ecfg.stuck_on   = cfg_q[cet_pkg::CFG_STUCK_BIT];
      ecfg.stuck_tout = tout_q;
    end
    cet_electrode u_elec (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .sample_valid (sample_valid && scan_enable_q[g]),
      .reading      (sample_data[g*16 +: 16]),
      .cfg          (ecfg),
      .touched_q    (elec_touched[g]),
      .baseline_q   ()
    );
  end

  // Status copy and wake pulse on a fresh touch of the shutdown electrode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      touch_status_q <= 4'h0;
      wake_q         <= 1'b0;
    end else begin
      touch_status_q <= elec_touched & en_q[3:0];
      wake_q <= (mode_q == CET_SD_LP) && elec_touched[low_power_electrode_select_q[1:0]]
                && !touch_status_q[low_power_electrode_select_q[1:0]];
    end
  end

  lp_no_scan_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !shutdown && lp_flag |=> scan_enable_q == 4'h0)
    else $error("electrodes scanned in run with low-power flag");

  run_scan_mask_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !shutdown && !lp_flag |=> scan_enable_q == $past(en_q[3:0]))
    else $error("run scan set differs from enable mask");

  sd_select_a: assert property (@(posedge core_clk) disable iff (!nrst)
    shutdown && lp_flag |=> scan_enable_q == 4'(4'h1 << $past(low_power_electrode_select_q[1:0])))
    else $error("shutdown scan not on selected electrode");

  cfg_reserved_a: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_req.rd && reg_req.addr == cet_pkg::ADDR_CFG
    |=> (rd_data_q & ~cet_pkg::CFG_MASK) == 8'h00)
    else $error("reserved config bits read nonzero");

  wake_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wake_q |-> $past(mode_q) == CET_SD_LP && $past(elec_touched[low_power_electrode_select_q[1:0]]))
    else $error("wake without selected electrode touch");

  lp_pace_a: assert property (@(posedge core_clk) disable iff (!nrst)
    lp_scan_req_q |-> $past(lp_ms_q) + 9'h001 >= $past(lp_ms_lim))
    else $error("low-power scan issued before coded interval");

  // Register masking, reset of the low-power flag, low-power pacing and wake width
  rsvd_read_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_req.rd |=> (rd_data_q & ~$past(rd_mask)) == 8'h00)
    else $error("reserved register bits read nonzero");

  lp_reset_clr_a: assert property (@(posedge core_clk)
    !nrst |=> !lp_flag)
    else $error("low-power flag survived reset");

  pace_gap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    lp_gap_ok_q |-> lp_scan_req_q == (lp_gap_q == lp_period))
    else $error("low-power scan spacing differs from coded interval");

  lp_run_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_q != CET_SD_LP |=> !lp_scan_req_q)
    else $error("low-power scan requested outside shutdown");

  wake_single_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wake_q && $stable(low_power_electrode_select_q) |=> !wake_q)
    else $error("wake pulse longer than one cycle");
endmodule
